// ===== common/dac_frame_pkg.sv
// Constants, field layout and helpers shared by the serial DAC front end.
package dac_frame_pkg;
    localparam int FRAME_BITS = 24;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] FRAME_CNT = 8'h18;
    localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
    localparam int FIXED_BIT = 20;
    localparam int ADDR_HI = 19;
    localparam int ADDR_LO = 16;
    localparam int WORD_W = 16;
    // Control register field layout.
    localparam int CTRL_W = 11;
    localparam int RANGE_LO = 0;
    localparam int RANGE_HI = 2;
    localparam int PWRUP_LO = 3;
    localparam int PWRUP_HI = 4;
    localparam int ETS_BIT = 6;
    localparam int B2C_BIT = 7;
    localparam int OVR_BIT = 8;
    localparam int CLR_LO = 9;
    localparam int CLR_HI = 10;
    localparam int SDO_DIS_BIT = 0;
    localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
    localparam logic [WORD_W-1:0] CODE_LOW = 16'h0000;
    localparam logic [WORD_W-1:0] CODE_MID = 16'h8000;
    localparam logic [WORD_W-1:0] CODE_HIGH = 16'hFFFF;
    localparam logic [WORD_W-1:0] CODE_TC_HIGH = 16'h7FFF;
    localparam logic [1:0] SEL_ZERO = 2'h0;
    localparam logic [1:0] SEL_MID = 2'h1;
    // Address field commands.
    localparam logic [3:0] CMD_WR_INPUT = 4'h1;
    localparam logic [3:0] CMD_UPDATE = 4'h2;
    localparam logic [3:0] CMD_WR_UPDATE = 4'h3;
    localparam logic [3:0] CMD_WR_CTRL = 4'h4;
    localparam logic [3:0] CMD_DATA_RST = 4'h7;
    localparam logic [3:0] CMD_CHAIN_OFF = 4'h9;
    localparam logic [3:0] CMD_RD_INPUT = 4'hA;
    localparam logic [3:0] CMD_RD_DAC = 4'hB;
    localparam logic [3:0] CMD_RD_CTRL = 4'hC;
    localparam logic [3:0] CMD_FULL_RST = 4'hF;
    localparam logic [2:0] RB_PAD = 3'h0;

    // Zero, mid or full scale in the coding that the range currently uses.
    function automatic logic [WORD_W-1:0] scale_code(input logic [1:0] sel, input logic tc);
        logic [WORD_W-1:0] c;
        c = tc ? CODE_TC_HIGH : CODE_HIGH;
        if (sel == SEL_ZERO) begin
            c = tc ? CODE_MID : CODE_LOW;
        end else if (sel == SEL_MID) begin
            c = tc ? CODE_LOW : CODE_MID;
        end
        return c;
    endfunction : scale_code
endpackage : dac_frame_pkg

// ===== rtl/dac_frame_ctrl.sv
// Serial frame decoder, register set and pin control of a single-channel DAC.
//
// How it works
// - A frame is a low frame_select_n; serial_data_in sampled on falling shift clock.
// - Frames ending before the 24th falling edge are ignored.
// - Standalone frames with more than 24 falling edges are ignored.
// - On frame end the word is decoded and written to the addressed register.
// - After a readback command, the next 24 clocks shift the register out.
// - serial_data_out goes high impedance two reference clocks after frame_select_n goes high.
// - Data output must be enabled for readback; enabled after reset.
// - Overflow bits appear on serial_data_out, launched on rising shift clock.
// - Frame end latches the held word and stops further shifting.
// - load_dac_n low during shifting updates the DAC at frame end.
// - Otherwise a falling load_dac_n after the frame updates the DAC.
// - Reset pin or full reset command restores power-on state.
// - Falling clear edge forces the clear_code_sel code until next DAC load.
// - Alert is low after reset and goes high after first control write.
// - Short circuit, brownout or overtemperature pull alert low; short circuit and brownout flags are reported.
// - Overtemperature powers down the digital supply only with thermal_shutdown_en.
// - range_sel picks the output range; bipolar ranges may use twos complement.
// - Frame is MSB first: three ignored bits, zero bit, address, data.
// - The address field selects write, update, control, reset, chain and readback.
// - Output stays clamped and buffer powered down until the first control write.
`timescale 1ns/1ns
module dac_frame_ctrl import dac_frame_pkg::*; #(
    parameter int DATA_W = 16,
    parameter logic [7:0] BIPOLAR_RANGES = 8'h0F
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic shift_clk_i,
    input wire logic frame_select_n_i,
    input wire logic serial_data_in_i,
    output logic serial_data_out_o,
    output logic serial_data_out_oe_o,
    input wire logic load_dac_n_i,
    input wire logic clear_n_i,
    input wire logic short_circuit_i,
    input wire logic brownout_i,
    input wire logic overtemp_i,
    output logic [DATA_W-1:0] dac_code_o,
    output logic [2:0] range_sel_o,
    output logic overrange_en_o,
    output logic bipolar_twos_comp_sel_o,
    output logic output_clamp_o,
    output logic buffer_pd_o,
    output logic supply_pd_o,
    output logic alert_n_o
);
    // Link side, clocked by the host's shift clock.
    typedef struct packed {
        logic [FRAME_BITS-1:0] shift;
        logic [CNT_W-1:0] cnt;
        logic frame_tog;
    } link_t;

    typedef struct packed {
        logic [2:0] fs_s;
        logic [2:0] ld_s;
        logic [2:0] clr_s;
        logic [2:0] flt_s1;
        logic [2:0] flt_s2;
        logic [WORD_W-1:0] input_reg;
        logic [WORD_W-1:0] dac_reg;
        logic [CTRL_W-1:0] ctrl;
        logic sc_flag;
        logic bo_flag;
        logic ot_flag;
        logic configured;
        logic chain_en;
        logic sdo_en;
        logic rb_valid;
        logic [FRAME_BITS-1:0] rb_word;
        logic tog_seen;
    } core_t;

    localparam core_t CORE_RST = '{fs_s: 3'h7, ld_s: 3'h7, clr_s: 3'h7, flt_s1: 3'h0,
        flt_s2: 3'h0, input_reg: WORD_RST, dac_reg: WORD_RST, ctrl: CTRL_RST,
        sc_flag: 1'b0, bo_flag: 1'b0, ot_flag: 1'b0, configured: 1'b0,
        chain_en: 1'b1, sdo_en: 1'b1, rb_valid: 1'b0, rb_word: '0, tog_seen: 1'b0};

    link_t link_q, link_d;
    core_t core_q, core_d;
    logic in_frame_q;
    logic sdo_q;
    logic [FRAME_BITS-1:0] load_word;

    // The preload crosses as quasi-static data: the core changes it only while
    // frame_select_n is high, well before the first edge of the next frame.
    assign load_word = core_q.rb_valid ? core_q.rb_word : link_q.shift;

    // Cleared asynchronously while the frame is idle so the next frame knows its first edge.
    always_ff @(negedge shift_clk_i or posedge frame_select_n_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            in_frame_q <= 1'b0;
        end else if (frame_select_n_i) begin
            in_frame_q <= 1'b0;
        end else begin
            in_frame_q <= 1'b1;
        end
    end

    always_comb begin
        link_d = link_q;
        if (!frame_select_n_i) begin
            if (!in_frame_q) begin
                link_d.cnt = CNT_W'(1);
                link_d.frame_tog = !link_q.frame_tog;
                link_d.shift = {load_word[FRAME_BITS-2:0], serial_data_in_i};
            end else begin
                if (link_q.cnt != CNT_MAX) begin
                    link_d.cnt = link_q.cnt + CNT_W'(1);
                end
                link_d.shift = {link_q.shift[FRAME_BITS-2:0], serial_data_in_i};
            end
        end
    end

    always_ff @(negedge shift_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            link_q <= '0;
        end else begin
            link_q <= link_d;
        end
    end

    // Overflow bits and all readback bits after the first launch on the rising edge, valid at the next fall.
    always_ff @(posedge shift_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sdo_q <= 1'b0;
        end else begin
            sdo_q <= link_q.shift[FRAME_BITS-1];
        end
    end

    assign serial_data_out_o = in_frame_q ? sdo_q : load_word[FRAME_BITS-1];
    // Enable follows the synchronised frame select, so it lags the pin by two clocks.
    assign serial_data_out_oe_o = !core_q.fs_s[1] && core_q.sdo_en;

    // Core side on the reference clock.
    logic frame_end;
    logic cnt_ok;
    logic [3:0] cmd;
    logic [WORD_W-1:0] data;
    logic ld_fall;
    logic clr_fall;
    logic bipolar_tc;
    logic full_rst;
    logic frame_new;

    assign frame_end = core_q.fs_s[1] && !core_q.fs_s[2];
    assign cmd = link_q.shift[ADDR_HI:ADDR_LO];
    assign data = link_q.shift[WORD_W-1:0];
    // A frame with no shift clocks leaves the old count and word behind; the toggle stops a replay.
    assign frame_new = link_q.frame_tog != core_q.tog_seen;
    assign cnt_ok = frame_new && ((link_q.cnt == FRAME_CNT)
        || (core_q.chain_en && link_q.cnt != CNT_MAX && link_q.cnt % FRAME_CNT == '0));
    assign ld_fall = !core_q.ld_s[1] && core_q.ld_s[2];
    assign clr_fall = !core_q.clr_s[1] && core_q.clr_s[2];
    assign bipolar_tc = core_q.ctrl[B2C_BIT] && BIPOLAR_RANGES[core_q.ctrl[RANGE_HI:RANGE_LO]];
    assign full_rst = frame_end && cnt_ok && !link_q.shift[FIXED_BIT] && cmd == CMD_FULL_RST;

    always_comb begin
        core_d = core_q;
        core_d.fs_s = {core_q.fs_s[1:0], frame_select_n_i};
        core_d.ld_s = {core_q.ld_s[1:0], load_dac_n_i};
        core_d.clr_s = {core_q.clr_s[1:0], clear_n_i};
        core_d.flt_s1 = {overtemp_i, brownout_i, short_circuit_i};
        core_d.flt_s2 = core_q.flt_s1;
        if (ld_fall && core_q.fs_s[1]) begin
            core_d.dac_reg = core_q.input_reg;
        end
        if (frame_end) begin
            core_d.rb_valid = 1'b0;
            core_d.tog_seen = link_q.frame_tog;
            if (cnt_ok && !link_q.shift[FIXED_BIT]) begin
                unique case (cmd)
                    CMD_WR_INPUT: begin
                        core_d.input_reg = data;
                        if (!core_q.ld_s[1]) begin
                            core_d.dac_reg = data;
                        end
                    end
                    CMD_UPDATE: core_d.dac_reg = core_q.input_reg;
                    CMD_WR_UPDATE: begin
                        core_d.input_reg = data;
                        core_d.dac_reg = data;
                    end
                    CMD_WR_CTRL: begin
                        core_d.ctrl = data[CTRL_W-1:0];
                        core_d.configured = 1'b1;
                        core_d.sc_flag = 1'b0;
                        core_d.bo_flag = 1'b0;
                        core_d.ot_flag = 1'b0;
                    end
                    CMD_DATA_RST: begin
                        core_d.input_reg = scale_code(core_q.ctrl[PWRUP_HI:PWRUP_LO], bipolar_tc);
                        core_d.dac_reg = core_d.input_reg;
                    end
                    CMD_CHAIN_OFF: begin
                        core_d.chain_en = 1'b0;
                        core_d.sdo_en = !data[SDO_DIS_BIT];
                    end
                    CMD_RD_INPUT, CMD_RD_DAC, CMD_RD_CTRL: begin
                        core_d.rb_valid = 1'b1;
                        core_d.rb_word = {RB_PAD, 1'b0, cmd, core_q.input_reg};
                        if (cmd == CMD_RD_DAC) begin
                            core_d.rb_word[WORD_W-1:0] = core_q.dac_reg;
                        end else if (cmd == CMD_RD_CTRL) begin
                            core_d.rb_word[WORD_W-1:0] =
                                {3'h0, core_q.sc_flag, core_q.bo_flag, core_q.ctrl};
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
        if (clr_fall) begin
            core_d.dac_reg = scale_code(core_q.ctrl[CLR_HI:CLR_LO], bipolar_tc);
        end
        // Faults are sticky; a fault in the clearing cycle still sets its flag.
        core_d.sc_flag = core_d.sc_flag || core_q.flt_s2[0];
        core_d.bo_flag = core_d.bo_flag || core_q.flt_s2[1];
        core_d.ot_flag = core_d.ot_flag || core_q.flt_s2[2];
        if (full_rst) begin
            core_d = CORE_RST;
            core_d.tog_seen = link_q.frame_tog;
            core_d.fs_s = {core_q.fs_s[1:0], frame_select_n_i};
            core_d.ld_s = {core_q.ld_s[1:0], load_dac_n_i};
            core_d.clr_s = {core_q.clr_s[1:0], clear_n_i};
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            core_q <= CORE_RST;
        end else begin
            core_q <= core_d;
        end
    end

    assign dac_code_o = core_q.dac_reg[WORD_W-1 -: DATA_W];
    assign range_sel_o = core_q.ctrl[RANGE_HI:RANGE_LO];
    assign overrange_en_o = core_q.ctrl[OVR_BIT];
    assign bipolar_twos_comp_sel_o = core_q.ctrl[B2C_BIT];
    assign output_clamp_o = !core_q.configured;
    assign buffer_pd_o = !core_q.configured;
    // Only the thermal event may cut the supply; the other faults just raise alert.
    assign supply_pd_o = core_q.flt_s2[2] && core_q.ctrl[ETS_BIT];
    assign alert_n_o = core_q.configured && !(core_q.sc_flag || core_q.bo_flag
        || core_q.ot_flag);

    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    clamp_release_a: assert property (frame_end && cnt_ok && cmd == CMD_WR_CTRL
        && !link_q.shift[FIXED_BIT] |=> !output_clamp_o && !buffer_pd_o)
        else $error("Clamp not released after control write.");
    short_frame_a: assert property (frame_end && link_q.cnt < FRAME_CNT && !clr_fall
        && !ld_fall |=> $stable(core_q.input_reg) && $stable(core_q.dac_reg))
        else $error("Short frame changed a register.");
    long_frame_a: assert property (frame_end && link_q.cnt > FRAME_CNT && !core_q.chain_en
        && !clr_fall && !ld_fall |=> $stable(core_q.input_reg) && $stable(core_q.ctrl))
        else $error("Long standalone frame was applied.");
    input_write_a: assert property (frame_end && cnt_ok && cmd == CMD_WR_INPUT
        && !link_q.shift[FIXED_BIT] |=> core_q.input_reg == $past(data))
        else $error("Input register not written.");
    sync_update_a: assert property (frame_end && cnt_ok && cmd == CMD_WR_INPUT
        && !link_q.shift[FIXED_BIT] && !core_q.ld_s[1] && !clr_fall
        |=> core_q.dac_reg == core_q.input_reg)
        else $error("Synchronous update missed.");
    async_update_a: assert property (ld_fall && core_q.fs_s[1] && !frame_end && !clr_fall
        |=> core_q.dac_reg == $past(core_q.input_reg))
        else $error("Load pin update missed.");
    clear_code_a: assert property (clr_fall && !full_rst
        |=> core_q.dac_reg == scale_code($past(core_q.ctrl[CLR_HI:CLR_LO]), $past(bipolar_tc)))
        else $error("Clear code not applied.");
    sdo_tristate_a: assert property (frame_select_n_i [*2] |=> !serial_data_out_oe_o)
        else $error("Data output driven outside a frame.");
    alert_low_a: assert property (full_rst |=> !alert_n_o && output_clamp_o)
        else $error("Alert high after full reset.");
    supply_cut_a: assert property (core_q.flt_s2[2] && !core_q.ctrl[ETS_BIT]
        |-> !supply_pd_o) else $error("Supply cut with shutdown disabled.");
    stale_frame_a: assert property (frame_end && !frame_new && !clr_fall && !ld_fall
        |=> $stable(core_q.input_reg) && $stable(core_q.dac_reg) && $stable(core_q.ctrl))
        else $error("Frame without shift clocks changed a register.");

    cov_write_c: cover property (frame_end && cnt_ok && cmd == CMD_WR_UPDATE);
    cov_read_c: cover property (frame_end && cnt_ok && cmd == CMD_RD_CTRL);
    cov_chain_c: cover property (frame_end && cnt_ok && link_q.cnt > FRAME_CNT);
    cov_clear_c: cover property (clr_fall ##[1:20] ld_fall);
    cov_data_rst_c: cover property (frame_end && cnt_ok && cmd == CMD_DATA_RST);
endmodule : dac_frame_ctrl

// ===== verif/host_spi_model.sv
// Host serial master model that frames words and captures readback data.
`timescale 1ns/1ns
module host_spi_model (
    output logic shift_clk_o,
    output logic frame_select_n_o,
    output logic serial_data_o,
    input wire logic serial_data_i
);
    logic [47:0] rx_q;

    // The shift clock idles high and stands still between frames.
    initial begin
        shift_clk_o = 1'b1;
        frame_select_n_o = 1'b1;
        serial_data_o = 1'b0;
        rx_q = '0;
    end

    // Sends the low n bits of w, MSB first, in one gated burst at a 15 ns period.
    task automatic xfer(input logic [47:0] w, input int n);
        frame_select_n_o = 1'b0;
        #200;
        for (int i = n - 1; i >= 0; i--) begin
            serial_data_o = w[i];
            #7 shift_clk_o = 1'b0;
            rx_q = {rx_q[46:0], serial_data_i};
            #8 shift_clk_o = 1'b1;
        end
        #10 frame_select_n_o = 1'b1;
        // The released data line flips so a stale level is never mistaken for data.
        serial_data_o = ~serial_data_o;
        #400;
    endtask : xfer
endmodule : host_spi_model

// ===== verif/tb.sv
// Testbench for the serial DAC front end driven by a host serial model.
`timescale 1ns/1ns
module tb import dac_frame_pkg::*;;
    typedef struct packed {
        logic [47:0] w;
        logic [5:0] n;
        logic [15:0] dac;
        logic [2:0] rng;
        logic clamp;
        logic alert;
    } row_t;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b1;
    logic load_dac_n_i = 1'b1;
    logic clear_n_i = 1'b1;
    logic short_circuit_i = 1'b0;
    logic brownout_i = 1'b0;
    logic overtemp_i = 1'b0;
    logic shift_clk, frame_select_n, serial_data_in, serial_data_out, sdo_oe, ovr, b2c, clamp, buf_pd, sup_pd, alert_n;
    logic [15:0] dac_code;
    logic [2:0] range_sel;
    wire sdo_line;
    int error_cnt = 0;
    int n_compared = 0;
    logic [15:0] clr_exp [3] = '{16'h0000, 16'h8000, 16'hFFFF};
    row_t rows [10] = '{
        '{48'h040005, 6'h18, 16'h0000, 3'h5, 1'b0, 1'b1},
        '{48'h011234, 6'h18, 16'h0000, 3'h5, 1'b0, 1'b1},
        '{48'h020000, 6'h18, 16'h1234, 3'h5, 1'b0, 1'b1},
        '{48'h035678, 6'h18, 16'h5678, 3'h5, 1'b0, 1'b1},
        '{48'h039999, 6'h17, 16'h5678, 3'h5, 1'b0, 1'b1},
        '{48'h039999, 6'h19, 16'h5678, 3'h5, 1'b0, 1'b1},
        '{48'h139999, 6'h18, 16'h5678, 3'h5, 1'b0, 1'b1},
        '{48'h08FFFF, 6'h18, 16'h5678, 3'h5, 1'b0, 1'b1},
        '{48'h0DFFFF, 6'h18, 16'h5678, 3'h5, 1'b0, 1'b1},
        '{48'hF5A5A5030AAA, 6'h30, 16'h0AAA, 3'h5, 1'b0, 1'b1}
    };

    // No pull on the data out line, so an undriven line reads as high impedance (z).
    assign sdo_line = sdo_oe ? serial_data_out : 1'bz;

    dac_frame_ctrl #(.DATA_W(16)) dut (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .shift_clk_i(shift_clk),
        .frame_select_n_i(frame_select_n), .serial_data_in_i(serial_data_in),
        .serial_data_out_o(serial_data_out), .serial_data_out_oe_o(sdo_oe),
        .load_dac_n_i(load_dac_n_i), .clear_n_i(clear_n_i),
        .short_circuit_i(short_circuit_i), .brownout_i(brownout_i),
        .overtemp_i(overtemp_i), .dac_code_o(dac_code), .range_sel_o(range_sel),
        .overrange_en_o(ovr), .bipolar_twos_comp_sel_o(b2c), .output_clamp_o(clamp),
        .buffer_pd_o(buf_pd), .supply_pd_o(sup_pd), .alert_n_o(alert_n)
    );

    host_spi_model host (
        .shift_clk_o(shift_clk), .frame_select_n_o(frame_select_n),
        .serial_data_o(serial_data_in), .serial_data_i(sdo_line)
    );

    initial begin
        forever #25 ref_clk_i = ~ref_clk_i;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : tick

    // Decode lands about three core clocks after the frame ends, eight leaves margin.
    task automatic send(input logic [47:0] w, input int n);
        host.xfer(w, n);
        tick(8);
    endtask : send

    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic readback(input logic [23:0] exp);
        send(48'h0C0000, 24);
        fork
            send(48'h000000, 24);
            begin
                #180;
                chk("sdo_oe", 24'h1, 24'(sdo_oe));
            end
        join
        chk("readback", exp, host.rx_q[23:0]);
        chk("sdo_oe", 24'h0, 24'(sdo_oe));
    endtask : readback

    task automatic chk_state();
        chk("dac_code", 24'h0, 24'(dac_code));
        chk("range_sel", 24'h0, 24'(range_sel));
        chk("clamp", 24'h1, 24'(clamp));
        chk("buf_pd", 24'h1, 24'(buf_pd));
        chk("alert_n", 24'h0, 24'(alert_n));
    endtask : chk_state

    task automatic close_out();
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    initial begin
        // Reset falls by a nonblocking write at time zero so that the shift-clock side sees its edge.
        rst_n_i <= 1'b0;
        repeat (20) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        tick(4);
        chk_state();
        foreach (rows[i]) begin
            send(rows[i].w, int'(rows[i].n));
            chk("dac_code", 24'(rows[i].dac), 24'(dac_code));
            chk("range_sel", 24'(rows[i].rng), 24'(range_sel));
            chk("clamp", 24'(rows[i].clamp), 24'(clamp));
            chk("buf_pd", 24'(rows[i].clamp), 24'(buf_pd));
            chk("alert_n", 24'(rows[i].alert), 24'(alert_n));
        end
        chk("chain_old", 24'h0DFFFF, host.rx_q[47:24]);
        chk("chain_out", 24'hF5A5A5, host.rx_q[23:0]);
        send(48'h011111, 24);
        chk("dac_code", 24'h000AAA, 24'(dac_code));
        @(posedge ref_clk_i);
        load_dac_n_i <= 1'b0;
        tick(6);
        chk("dac_code", 24'h001111, 24'(dac_code));
        send(48'h012222, 24);
        chk("dac_code", 24'h002222, 24'(dac_code));
        @(posedge ref_clk_i);
        load_dac_n_i <= 1'b1;
        for (int s = 0; s < 3; s++) begin
            send(48'h040005 | (48'(s) << 9), 24);
            @(posedge ref_clk_i);
            clear_n_i <= 1'b0;
            tick(6);
            chk("clear_code", 24'(clr_exp[s]), 24'(dac_code));
            @(posedge ref_clk_i);
            clear_n_i <= 1'b1;
        end
        readback(24'h0C0405);
        send(48'h0401C5, 24);
        chk("overrange_en", 24'h1, 24'(ovr));
        chk("twos_comp_sel", 24'h1, 24'(b2c));
        @(posedge ref_clk_i);
        overtemp_i <= 1'b1;
        tick(6);
        chk("alert_n", 24'h0, 24'(alert_n));
        chk("supply_pd", 24'h1, 24'(sup_pd));
        @(posedge ref_clk_i);
        overtemp_i <= 1'b0;
        send(48'h040005, 24);
        chk("alert_n", 24'h1, 24'(alert_n));
        @(posedge ref_clk_i);
        overtemp_i <= 1'b1;
        tick(6);
        chk("supply_pd", 24'h0, 24'(sup_pd));
        chk("alert_n", 24'h0, 24'(alert_n));
        @(posedge ref_clk_i);
        overtemp_i <= 1'b0;
        send(48'h000000, 0);
        chk("alert_n", 24'h0, 24'(alert_n));
        @(posedge ref_clk_i);
        short_circuit_i <= 1'b1;
        brownout_i <= 1'b1;
        tick(6);
        readback(24'h0C1805);
        @(posedge ref_clk_i);
        short_circuit_i <= 1'b0;
        brownout_i <= 1'b0;
        send(48'h0F0000, 24);
        chk_state();
        send(48'h040480, 24);
        send(48'h070000, 24);
        chk("data_reset", 24'h008000, 24'(dac_code));
        @(posedge ref_clk_i);
        clear_n_i <= 1'b0;
        tick(6);
        chk("clear_code", 24'h007FFF, 24'(dac_code));
        @(posedge ref_clk_i);
        clear_n_i <= 1'b1;
        send(48'h090000, 24);
        send(48'h03BEEF, 48);
        chk("dac_code", 24'h007FFF, 24'(dac_code));
        @(posedge ref_clk_i);
        rst_n_i <= 1'b0;
        tick(2);
        chk_state();
        @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        tick(4);
        send(48'h040005, 24);
        chk("alert_n", 24'h1, 24'(alert_n));
        close_out();
    end
endmodule : tb
